// ---- verilog/spi_port_params.svh ----
/*
 * Constants of the paged SPI register port: command byte fields, page codes,
 * address limits and link timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// Command byte fields
`define SPI_CMD_ADDR_MSB 7
`define SPI_CMD_ADDR_LSB 1
`define SPI_CMD_DIR_BIT 0
`define SPI_DIR_WRITE 1'b0
`define SPI_DIR_READ 1'b1

// Byte framing
`define SPI_LAST_BIT 3'h7
`define SPI_BIT_CNT_RESET 3'h0
`define SPI_TX_IDLE 8'h00

// Address map
`define SPI_PAGE_SELECT_ADDR 7'h00
`define SPI_LAST_ADDR 7'h7F
`define SPI_ADDR_RESET 7'h00

// Page select codes and reset page
`define SPI_PAGE0_CODE 8'h00
`define SPI_PAGE1_CODE 8'h01
`define SPI_PAGE_RESET 1'b0
`define SPI_REG_RESET 8'h00

// Synchroniser reset levels: select high, clock low, data low, mode low
`define SPI_SYNC_RESET 4'h1

// Host side timing figures
`define SPI_SYS_CLK_PERIOD_NS 25
`define SPI_CS_GAP_NS 6250
`define SPI_CS_GAP_CYCLES ((`SPI_CS_GAP_NS + `SPI_SYS_CLK_PERIOD_NS - 1) / `SPI_SYS_CLK_PERIOD_NS)

`endif

// ---- verilog/spi_port_pkg.sv ----
/*
 * Types of the paged SPI register port.
 * Assumes nothing of its surroundings.
 */
package spi_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_HALT
    } spi_state_t;

endpackage : spi_port_pkg

// ---- verilog/pin_sync.sv ----
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the outputs are read only in the i_clk_sys domain.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_reg;
            logic meta_next;
            logic sync_reg;
            logic sync_next;
            always_comb begin
                meta_next = i_ce ? i_async[g] : meta_reg;
                sync_next = i_ce ? meta_reg : sync_reg;
            end
            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    meta_reg <= RESET_VAL[g];
                    sync_reg <= RESET_VAL[g];
                end else begin
                    meta_reg <= meta_next;
                    sync_reg <= sync_next;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule : pin_sync

// ---- verilog/page_reg_file.sv ----
/*
 * Two pages of 128 eight-bit registers, one write port, one async read port.
 * Assumes address 0 is handled by the caller as the page select register.
 */
`timescale 1ns/1ps
`include "spi_port_params.svh"

module page_reg_file #(
    parameter int PAGES = 2,
    parameter int ADDR_W = 7
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Write port
    input wire logic i_wr_en,
    input wire logic i_wr_page,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    // Read port
    input wire logic i_rd_page,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);

    localparam int DEPTH = PAGES << ADDR_W;

    logic [7:0] mem_reg [DEPTH];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= `SPI_REG_RESET;
            end
        end else if (i_ce && i_wr_en) begin
            mem_reg[{i_wr_page, i_wr_addr}] <= i_wr_data;
        end
    end

    assign o_rd_data = mem_reg[{i_rd_page, i_rd_addr}];

endmodule : page_reg_file

// ---- verilog/paged_spi_register_port.sv ----
/*
 * SPI slave control port with a paged 8-bit register map (mode 1: idle-low
 * clock, change on rising edge, sample on falling edge, MSB first).
 * Assumes the master clock, select and data arrive asynchronously and that
 * the master clock is at most a quarter of i_clk_sys.
 */
`timescale 1ns/1ps
`include "spi_port_params.svh"

module paged_spi_register_port #(
    parameter int ADDR_W = 7
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Protocol select, high for SPI
    input wire logic i_protocol_select,
    // SPI pins
    input wire logic i_spi_select_n,
    input wire logic i_multi_pin_1,
    input wire logic i_multi_pin_3,
    output logic o_multi_pin_2,
    output logic o_multi_pin_2_oe,
    // Register write notifications to the codec core
    output logic o_wr_strobe,
    output logic o_wr_page,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_active_page
);

    // Address decode shared by read and write paths
    function automatic logic is_page_sel(input logic [ADDR_W-1:0] addr);
        is_page_sel = (addr == `SPI_PAGE_SELECT_ADDR);
    endfunction : is_page_sel

    // Synchronised pins
    logic [3:0] pins_s;
    logic spi_mode_s;
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;

    pin_sync #(
        .WIDTH(4),
        .RESET_VAL(`SPI_SYNC_RESET)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async({i_protocol_select, i_multi_pin_3, i_multi_pin_1, i_spi_select_n}),
        .o_sync(pins_s)
    );

    assign cs_n_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[2];
    assign spi_mode_s = pins_s[3];

    // State
    spi_port_pkg::spi_state_t state_reg;
    spi_port_pkg::spi_state_t state_next;
    logic cs_n_prev_reg;
    logic cs_n_prev_next;
    logic sclk_prev_reg;
    logic sclk_prev_next;
    logic [2:0] bit_cnt_reg;
    logic [2:0] bit_cnt_next;
    logic [7:0] rx_reg;
    logic [7:0] rx_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic miso_reg;
    logic miso_next;
    logic oe_reg;
    logic oe_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic page_reg;
    logic page_next;
    logic wr_strobe_reg;
    logic wr_strobe_next;
    logic wr_page_reg;
    logic wr_page_next;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_addr_next;
    logic [7:0] wr_data_reg;
    logic [7:0] wr_data_next;

    // Events and datapath
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [ADDR_W-1:0] addr_inc;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_file;
    logic [7:0] rd_value;
    logic file_wr_en;

    assign cs_fall = i_ce && cs_n_prev_reg && !cs_n_s;
    assign cs_rise = i_ce && !cs_n_prev_reg && cs_n_s;
    assign sclk_rise = i_ce && !sclk_prev_reg && sclk_s;
    assign sclk_fall = i_ce && sclk_prev_reg && !sclk_s;
    assign byte_done = sclk_fall && (bit_cnt_reg == `SPI_LAST_BIT);
    assign rx_byte = {rx_reg[6:0], mosi_s};
    assign addr_inc = ADDR_W'(addr_reg + 1'b1);
    assign rd_addr = (state_reg == spi_port_pkg::ST_CMD) ? rx_byte[`SPI_CMD_ADDR_MSB:`SPI_CMD_ADDR_LSB] : addr_inc;
    assign rd_value = is_page_sel(rd_addr) ? {7'h00, page_reg} : rd_file;

    page_reg_file #(
        .PAGES(2),
        .ADDR_W(ADDR_W)
    ) u_page_reg_file (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_wr_en(file_wr_en),
        .i_wr_page(page_reg),
        .i_wr_addr(addr_reg),
        .i_wr_data(rx_byte),
        .i_rd_page(page_reg),
        .i_rd_addr(rd_addr),
        .o_rd_data(rd_file)
    );

    always_comb begin
        state_next = state_reg;
        cs_n_prev_next = i_ce ? cs_n_s : cs_n_prev_reg;
        sclk_prev_next = i_ce ? sclk_s : sclk_prev_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        miso_next = miso_reg;
        addr_next = addr_reg;
        page_next = page_reg;
        wr_strobe_next = i_ce ? 1'b0 : wr_strobe_reg;
        wr_page_next = wr_page_reg;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        file_wr_en = 1'b0;
        if (!spi_mode_s || cs_rise) begin
            state_next = spi_port_pkg::ST_IDLE;
            miso_next = 1'b0;
        end else if (cs_fall) begin
            state_next = spi_port_pkg::ST_CMD;
            bit_cnt_next = `SPI_BIT_CNT_RESET;
            tx_next = `SPI_TX_IDLE;
            miso_next = 1'b0;
        end else if (state_reg != spi_port_pkg::ST_IDLE) begin
            if (sclk_rise) begin
                miso_next = tx_reg[7];
                tx_next = {tx_reg[6:0], 1'b0};
            end
            if (sclk_fall) begin
                rx_next = rx_byte;
                bit_cnt_next = 3'(bit_cnt_reg + 1'b1);
            end
            if (byte_done) begin
                unique case (state_reg)
                    spi_port_pkg::ST_CMD: begin
                        addr_next = rx_byte[`SPI_CMD_ADDR_MSB:`SPI_CMD_ADDR_LSB];
                        if (rx_byte[`SPI_CMD_DIR_BIT] == `SPI_DIR_WRITE) begin
                            state_next = spi_port_pkg::ST_WDATA;
                        end else begin
                            state_next = spi_port_pkg::ST_RDATA;
                            tx_next = rd_value;
                        end
                    end
                    spi_port_pkg::ST_WDATA: begin
                        wr_strobe_next = 1'b1;
                        wr_page_next = page_reg;
                        wr_addr_next = addr_reg;
                        wr_data_next = rx_byte;
                        if (is_page_sel(addr_reg)) begin
                            if (rx_byte == `SPI_PAGE1_CODE) begin
                                page_next = 1'b1;
                            end else if (rx_byte == `SPI_PAGE0_CODE) begin
                                page_next = 1'b0;
                            end
                        end else begin
                            file_wr_en = 1'b1;
                        end
                        if (addr_reg == `SPI_LAST_ADDR) begin
                            state_next = spi_port_pkg::ST_HALT;
                        end else begin
                            addr_next = addr_inc;
                        end
                    end
                    spi_port_pkg::ST_RDATA: begin
                        if (addr_reg == `SPI_LAST_ADDR) begin
                            state_next = spi_port_pkg::ST_HALT;
                            tx_next = `SPI_TX_IDLE;
                        end else begin
                            addr_next = addr_inc;
                            tx_next = rd_value;
                        end
                    end
                    spi_port_pkg::ST_HALT: begin
                        tx_next = `SPI_TX_IDLE;
                    end
                    default: begin
                        state_next = spi_port_pkg::ST_IDLE;
                    end
                endcase
            end
        end
        oe_next = (state_next != spi_port_pkg::ST_IDLE);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= spi_port_pkg::ST_IDLE;
            cs_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg <= `SPI_BIT_CNT_RESET;
            rx_reg <= `SPI_TX_IDLE;
            tx_reg <= `SPI_TX_IDLE;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            addr_reg <= `SPI_ADDR_RESET;
            page_reg <= `SPI_PAGE_RESET;
            wr_strobe_reg <= 1'b0;
            wr_page_reg <= 1'b0;
            wr_addr_reg <= `SPI_ADDR_RESET;
            wr_data_reg <= `SPI_REG_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
            cs_n_prev_reg <= cs_n_prev_next;
            sclk_prev_reg <= sclk_prev_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            addr_reg <= addr_next;
            page_reg <= page_next;
            wr_strobe_reg <= wr_strobe_next;
            wr_page_reg <= wr_page_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign o_multi_pin_2 = miso_reg;
    assign o_multi_pin_2_oe = oe_reg;
    assign o_wr_strobe = wr_strobe_reg;
    assign o_wr_page = wr_page_reg;
    assign o_wr_addr = wr_addr_reg;
    assign o_wr_data = wr_data_reg;
    assign o_active_page = page_reg;

    // Checks
    logic rst_done_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_done_reg <= 1'b0;
        end else begin
            rst_done_reg <= 1'b1;
        end
    end

    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    property p_page_after_reset;
        !rst_done_reg |-> (page_reg == 1'b0) && !oe_reg;
    endproperty
    a_page_after_reset: assert property (p_page_after_reset) else $error("Page not 0 after reset");
    property p_write_cmd;
        (state_reg == spi_port_pkg::ST_CMD) && byte_done && spi_mode_s && !rx_byte[0]
            |=> (state_reg == spi_port_pkg::ST_WDATA) && (addr_reg == $past(rx_byte[7:1]));
    endproperty
    a_write_cmd: assert property (p_write_cmd) else $error("Write command not decoded");
    property p_read_load;
        (state_reg == spi_port_pkg::ST_CMD) && byte_done && spi_mode_s && rx_byte[0]
            |=> (state_reg == spi_port_pkg::ST_RDATA) && (tx_reg == $past(rd_value));
    endproperty
    a_read_load: assert property (p_read_load) else $error("Read data not loaded");
    property p_page1_select;
        wr_strobe_next && i_ce && is_page_sel(addr_reg) && (rx_byte == 8'h01) |=> page_reg && o_active_page;
    endproperty
    a_page1_select: assert property (p_page1_select) else $error("Page 1 not selected");
    property p_frame_end;
        cs_rise |=> (state_reg == spi_port_pkg::ST_IDLE) && !o_multi_pin_2_oe && !o_multi_pin_2;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("Frame not ended by select rise");
    property p_miso_on_rise;
        $changed(miso_reg) |-> $past(sclk_rise || cs_fall || cs_rise || !spi_mode_s);
    endproperty
    a_miso_on_rise: assert property (p_miso_on_rise) else $error("Data out changed off rising edge");
    property p_no_write_halt;
        file_wr_en |-> (state_reg == spi_port_pkg::ST_WDATA) && !is_page_sel(addr_reg);
    endproperty
    a_no_write_halt: assert property (p_no_write_halt) else $error("Write outside write data phase");
    property p_addr_step;
        (state_reg == spi_port_pkg::ST_WDATA) && byte_done && spi_mode_s && (addr_reg != 7'h7F)
            |=> o_wr_strobe && (addr_reg == 7'($past(addr_reg) + 1'b1)) && (o_wr_data == $past(rx_byte));
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("Address not stepped after byte");
    property p_oe_idle;
        (state_reg == spi_port_pkg::ST_IDLE) |-> !o_multi_pin_2_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("Data out driven outside frame");

    c_write: cover property (o_wr_strobe && (o_wr_addr != 7'h00));
    c_read: cover property ((state_reg == spi_port_pkg::ST_RDATA) && byte_done);
    c_page1: cover property ($rose(page_reg));
    c_burst: cover property (o_wr_strobe ##[1:200] o_wr_strobe);

endmodule : paged_spi_register_port

// ---- dv/spi_host_model.sv ----
/*
 * Behavioural SPI master for the paged register port: mode 1, MSB first.
 * Assumes the caller starts each task just after a system clock edge.
 */
`timescale 1ns/1ps

module spi_host_model (
    // SPI pins
    output logic o_select_n,
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso
);
    int half_ns = 100;
    int gap_ns = 6250;

    initial begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end

    // Select fall opens a frame and command byte
    task automatic open_frame();
        o_select_n = 1'b0;
        #(half_ns);
    endtask : open_frame

    // Full duplex shift of nbits, MSB first
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            o_sclk = 1'b1;
            o_mosi = tx[i];
            #(half_ns);
            o_sclk = 1'b0;
            rx[i] = i_miso;
            #(half_ns);
        end
    endtask : xfer

    // Select rise ends frame, then long idle gap
    task automatic close_frame();
        o_select_n = 1'b1;
        o_mosi = ~o_mosi;
        #(gap_ns);
    endtask : close_frame
endmodule : spi_host_model

// ---- dv/paged_spi_register_port_tb_top.sv ----
/*
 * Self-checking bench of the paged SPI register port with a reference model.
 * Assumes the SPI host model in spi_host_model.sv and a 40 MHz system clock.
 */
`timescale 1ns/1ps

module paged_spi_register_port_tb_top;
    localparam time STEP = 7;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic i_protocol_select = 1'b0;
    logic select_n, sclk, mosi, miso;
    logic o_multi_pin_2, o_multi_pin_2_oe, o_wr_strobe, o_wr_page, o_active_page;
    logic [6:0] o_wr_addr;
    logic [7:0] o_wr_data;
    int err_total = 0;
    int comparisons = 0;
    int mem [2][128];
    int page = 0;
    logic [16:0] exp_q [$];

    always #12.5 i_clk_sys = ~i_clk_sys;
    // Released line shows a changing pattern
    assign miso = o_multi_pin_2_oe ? o_multi_pin_2 : i_clk_sys;

    paged_spi_register_port paged_spi_register_port_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_protocol_select(i_protocol_select),
        .i_spi_select_n(select_n),
        .i_multi_pin_1(sclk),
        .i_multi_pin_3(mosi),
        .o_multi_pin_2(o_multi_pin_2),
        .o_multi_pin_2_oe(o_multi_pin_2_oe),
        .o_wr_strobe(o_wr_strobe),
        .o_wr_page(o_wr_page),
        .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data),
        .o_active_page(o_active_page)
    );

    spi_host_model spi_host_model_inst (
        .o_select_n(select_n),
        .o_sclk(sclk),
        .o_mosi(mosi),
        .i_miso(miso)
    );

    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_wr(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_wr

    // Every write strobe matched against the model
    always @(negedge i_clk_sys) begin
        logic [16:0] e;
        if (o_wr_strobe === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_bit("unexpected write strobe", 1'b0, o_wr_strobe);
            end else begin
                e = exp_q.pop_front();
                cmp_wr("write record", e[15:0], {o_wr_page, o_wr_addr, o_wr_data});
            end
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #STEP;
    endtask : tick

    task automatic wr_frame(input int addr, input logic [7:0] dq [$], input int tail);
        logic [7:0] rx;
        int a;
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer({addr[6:0], 1'b0}, 8, rx);
        for (int k = 0; k < dq.size(); k++) begin
            a = addr + k;
            if (a <= 127) begin
                exp_q.push_back({a == 0, page[0], a[6:0], dq[k]});
                if (a == 0 && dq[k] <= 8'h01) page = dq[k];
                else if (a != 0) mem[page][a] = dq[k];
            end
            spi_host_model_inst.xfer(dq[k], 8, rx);
        end
        if (tail > 0) spi_host_model_inst.xfer(8'hA5, tail, rx);
        spi_host_model_inst.close_frame();
        cmp_byte("pending writes", 8'h00, 8'(exp_q.size()));
    endtask : wr_frame

    task automatic rd_frame(input int addr, input int n);
        logic [7:0] rx;
        int a;
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer({addr[6:0], 1'b1}, 8, rx);
        cmp_byte("command byte out", 8'h00, rx);
        cmp_bit("data out enable", 1'b1, o_multi_pin_2_oe);
        for (int k = 0; k < n; k++) begin
            a = addr + k;
            spi_host_model_inst.xfer(8'($urandom()), 8, rx);
            cmp_byte("read data", a == 0 ? 8'(page) : (a <= 127 ? 8'(mem[page][a]) : 8'h00), rx);
        end
        spi_host_model_inst.close_frame();
        cmp_bit("data out enable", 1'b0, o_multi_pin_2_oe);
    endtask : rd_frame

    initial begin
        #(1_000_000);
        err_total++;
        give_verdict();
    end

    initial begin
        logic [7:0] dq [$];
        logic [7:0] rx;
        logic [7:0] codes [3];
        codes = '{8'h01, 8'h02, 8'h00};
        void'($urandom(32'h607bbd89));
        // Port idle while protocol select is low
        tick(8);
        i_rst_b = 1'b1;
        tick(4);
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer(8'h06, 8, rx);
        spi_host_model_inst.xfer(8'h5A, 8, rx);
        cmp_bit("data out enable", 1'b0, o_multi_pin_2_oe);
        spi_host_model_inst.close_frame();
        // Second reset with SPI selected
        i_rst_b = 1'b0;
        i_protocol_select = 1'b1;
        tick(8);
        cmp_bit("active page", 1'b0, o_active_page);
        cmp_bit("write strobe", 1'b0, o_wr_strobe);
        i_rst_b = 1'b1;
        tick(4);
        rd_frame(0, 1);
        dq = {8'($urandom())};
        wr_frame(5, dq, 0);
        rd_frame(5, 1);
        dq = {8'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom())};
        wr_frame(16, dq, 0);
        rd_frame(16, 4);
        foreach (codes[i]) begin
            dq = {codes[i]};
            wr_frame(0, dq, 0);
            cmp_bit("active page", page[0], o_active_page);
            rd_frame(0, 1);
            dq = {8'($urandom())};
            wr_frame(5, dq, 0);
            rd_frame(5, 1);
        end
        dq = {8'($urandom()), 8'($urandom()), 8'($urandom())};
        wr_frame(126, dq, 0);
        rd_frame(126, 3);
        dq = {8'($urandom())};
        wr_frame(9, dq, 4);
        rd_frame(16, 2);
        rd_frame(9, 1);
        // Frozen port ignores a select fall
        i_ce = 1'b0;
        spi_host_model_inst.open_frame();
        tick(4);
        cmp_bit("data out enable", 1'b0, o_multi_pin_2_oe);
        spi_host_model_inst.close_frame();
        i_ce = 1'b1;
        tick(4);
        cmp_bit("data out enable", 1'b0, o_multi_pin_2_oe);
        // Reset returns page 1 to page 0
        dq = {8'h01};
        wr_frame(0, dq, 0);
        i_rst_b = 1'b0;
        tick(2);
        cmp_bit("active page", 1'b0, o_active_page);
        cmp_byte("write data", 8'h00, o_wr_data);
        page = 0;
        mem = '{default: 0};
        i_rst_b = 1'b1;
        tick(4);
        rd_frame(0, 1);
        tick(4);
        give_verdict();
    end
endmodule : paged_spi_register_port_tb_top
